// [rtl/fepcs_codec.sv]
// 100BASE-TX coding path: 4B/5B encode and scramble, descramble, align and decode
//
// How it works
// - /R/ right after /T/ drops carrier sense; elsewhere in a frame /R/ flags receive error.
// - Falling transmit enable sends /T/ then /R/ to close the frame.
// - A rising transmit error input puts /H/ into the outgoing stream.
// - Invalid groups during receive data valid flag error; transmitter never sends them.
// - Sleep group sent for low-power idle; received sleep run pulses a notice.
// - Scrambler seed comes from the configured PHY address.
// - Scrambler stage serializes groups; NRZI stream leaves at the bit rate.
// - MLT-3 steps one of three levels per one, holds per zero.
// - Descrambler undoes the scrambler and deserializes into five-bit groups.
// - Key learnt from idle stream, then held and free-running once locked.
// - No idle within the 4000-byte window drops lock and aborts reception.
// - Group boundaries fixed by /J/K/ and kept until the next frame.
// - /J/K/ come out as two 0101 nibbles, then data nibbles follow.
// - A good start delimiter raises receive data valid.
// - /T/R/ or two idles end carrier sense and receive data valid.
// - Nibbles map to the data code-groups and back.
// - Rising enable sends /J/ then /K/; receiver checks their order.
// - Bad start delimiter: receive error, nibble 1110, data valid stays low.
`timescale 1ns/1ps
module fepcs_codec
    import fepcs_pkg::*;
#(
    parameter int WINDOW_CYCLES = WINDOW_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [4:0] phy_addr_in,
    input wire logic mii_tx_en_in,
    input wire logic mii_tx_er_in,
    input wire logic [3:0] mii_txd_in,
    input wire logic lpi_req_in,
    input wire logic rx_bit_in,
    output logic mii_tx_stb_out,
    output logic tx_nrzi_out,
    output logic [1:0] tx_mlt3_out,
    output logic mii_rx_stb_out,
    output logic [3:0] mii_rxd_out,
    output logic mii_rx_dv_out,
    output logic mii_rx_er_out,
    output logic mii_crs_out,
    output logic rx_sleep_out,
    output logic rx_locked_out
);
    localparam int WD_W = $clog2(WINDOW_CYCLES + 1);

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ----------------------------------------------------------------
    // Transmit: nibble divider and encoder
    // ----------------------------------------------------------------
    fepcs_tx_if tx_if ();
    logic [2:0] div_reg;
    logic tx_stb_reg;
    logic load_reg;
    logic [4:0] grp_reg;
    logic er_prev_reg;
    fepcs_tx_state_t tx_st_reg;
    fepcs_tx_state_t tx_st_next;
    logic [4:0] grp_next;

    wire nib_en = (div_reg == GRP_LAST);
    wire er_rise = mii_tx_er_in && !er_prev_reg;

    // Next code-group chosen once per nibble period
    always_comb begin
        tx_st_next = tx_st_reg;
        grp_next = CG_IDLE;
        case (tx_st_reg)
            TX_IDLE: begin
                if (mii_tx_en_in) begin
                    grp_next = CG_J;
                    tx_st_next = TX_K;
                end else if (lpi_req_in) begin
                    grp_next = CG_P;
                end
            end
            TX_K: begin
                grp_next = CG_K;
                tx_st_next = TX_DATA;
            end
            TX_DATA: begin
                if (!mii_tx_en_in) begin
                    grp_next = CG_T;
                    tx_st_next = TX_R;
                end else if (er_rise) begin
                    grp_next = CG_H;
                end else begin
                    grp_next = fepcs_enc(mii_txd_in);
                end
            end
            default: begin
                grp_next = CG_R;
                tx_st_next = TX_IDLE;
            end
        endcase
    end

    // Divider gives one nibble slot per five code bits
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg <= '0;
            tx_stb_reg <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            div_reg <= nib_en ? '0 : 3'(div_reg + 3'h1);
            tx_stb_reg <= (div_reg == GRP_PRE);
            load_reg <= nib_en;
        end
    end

    // Only the listed code-groups can be produced, so invalid ones never leave
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_st_reg <= TX_IDLE;
            grp_reg <= CG_IDLE;
            er_prev_reg <= 1'b0;
        end else if (nib_en) begin
            tx_st_reg <= tx_st_next;
            grp_reg <= grp_next;
            er_prev_reg <= mii_tx_er_in;
        end
    end

    assign tx_if.grp = grp_reg;
    assign tx_if.load = load_reg;
    assign mii_tx_stb_out = tx_stb_reg;

    fepcs_tx_line u_line (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .phy_addr_in(phy_addr_in),
        .tx_if(tx_if),
        .tx_nrzi_out(tx_nrzi_out),
        .tx_mlt3_out(tx_mlt3_out)
    );

    property p_tx_sof;
        (load_reg && grp_reg == CG_J) |-> ##5 (load_reg && grp_reg == CG_K);
    endproperty
    a_tx_sof: assert property (p_tx_sof) else $error("J not followed by K");

    property p_tx_eos;
        (load_reg && grp_reg == CG_T) |-> ##5 (load_reg && grp_reg == CG_R);
    endproperty
    a_tx_eos: assert property (p_tx_eos) else $error("T not followed by R");

    property p_tx_err;
        (nib_en && tx_st_reg == TX_DATA && mii_tx_en_in && er_rise) |=> (grp_reg == CG_H);
    endproperty
    a_tx_err: assert property (p_tx_err) else $error("Error symbol not sent");

    property p_tx_idle;
        (nib_en && tx_st_reg == TX_IDLE && !mii_tx_en_in) |=>
            (grp_reg == ($past(lpi_req_in) ? CG_P : CG_IDLE));
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("Wrong group between frames");

    // ----------------------------------------------------------------
    // Receive: descrambler key and lock
    // ----------------------------------------------------------------
    logic [10:0] rkey_reg;
    logic [5:0] lock_cnt_reg;
    logic locked_reg;
    logic [9:0] sh_reg;
    logic [2:0] cnt_reg;
    logic [WD_W-1:0] wd_reg;

    wire rpred = rkey_reg[TAP_A] ^ rkey_reg[TAP_B];
    wire dbit = rx_bit_in ^ rpred;
    wire [9:0] sh_next = {sh_reg[8:0], dbit};
    wire [4:0] grp_now = sh_next[4:0];
    wire grp_evt = locked_reg && (cnt_reg == GRP_LAST);
    wire wd_expire = locked_reg && (wd_reg == WD_W'(WINDOW_CYCLES));

    // Unlocked, idle puts the inverted key on the line, so inverting it rebuilds the key
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rkey_reg <= '0;
            lock_cnt_reg <= '0;
            locked_reg <= 1'b0;
        end else if (!locked_reg) begin
            rkey_reg <= {rkey_reg[9:0], !rx_bit_in};
            lock_cnt_reg <= (rx_bit_in != rpred) ? 6'(lock_cnt_reg + 6'h01) : '0;
            locked_reg <= (lock_cnt_reg == LOCK_BITS);
        end else begin
            rkey_reg <= {rkey_reg[9:0], rpred};
            lock_cnt_reg <= '0;
            locked_reg <= !wd_expire;
        end
    end

    // Watchdog restarts on any two-idle run; long frames fit well inside it
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wd_reg <= '0;
        end else if (!locked_reg || sh_next == RUN_ONES) begin
            wd_reg <= '0;
        end else begin
            wd_reg <= WD_W'(wd_reg + 1'b1);
        end
    end

    // ----------------------------------------------------------------
    // Receive: alignment and decoding
    // ----------------------------------------------------------------
    fepcs_rx_state_t rx_st_reg;
    logic [4:0] prev_reg;
    logic [3:0] rxd_reg;
    logic dv_reg;
    logic er_reg;
    logic crs_reg;
    logic sleep_reg;
    logic rx_stb_reg;

    wire carrier = locked_reg && rx_st_reg == RX_SEARCH && sh_next[9:5] == CG_IDLE
        && ($countones(grp_now) <= CARRIER_MAX_ONES);
    wire j_ok = (grp_now == CG_J);
    wire [4:0] dec_prev = fepcs_dec(prev_reg);
    wire esd_pair = (prev_reg == CG_T) && (grp_now == CG_R);
    wire idle_pair = (prev_reg == CG_IDLE) && (grp_now == CG_IDLE);

    // Group counter realigns only on carrier, so alignment holds for the frame
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sh_reg <= RUN_ONES;
            cnt_reg <= '0;
        end else begin
            sh_reg <= sh_next;
            cnt_reg <= (carrier || cnt_reg == GRP_LAST) ? '0 : 3'(cnt_reg + 3'h1);
        end
    end

    // Decoded nibbles lag the line by one group so /T/R/ is never passed up
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_st_reg <= RX_SEARCH;
            prev_reg <= CG_IDLE;
            rxd_reg <= NIB_NONE;
            dv_reg <= 1'b0;
            er_reg <= 1'b0;
            crs_reg <= 1'b0;
        end else if (!locked_reg || wd_expire) begin
            rx_st_reg <= RX_SEARCH;
            dv_reg <= 1'b0;
            er_reg <= 1'b0;
            crs_reg <= 1'b0;
            rxd_reg <= NIB_NONE;
        end else if (carrier) begin
            rx_st_reg <= j_ok ? RX_K : RX_SEARCH;
            crs_reg <= j_ok;
            er_reg <= !j_ok;
            rxd_reg <= j_ok ? NIB_NONE : NIB_BAD_SSD;
        end else if (grp_evt) begin
            case (rx_st_reg)
                RX_K: begin
                    if (grp_now == CG_K) begin
                        rx_st_reg <= RX_FRAME;
                        dv_reg <= 1'b1;
                        er_reg <= 1'b0;
                        rxd_reg <= NIB_PREAMBLE;
                        prev_reg <= fepcs_enc(NIB_PREAMBLE);
                    end else begin
                        rx_st_reg <= RX_SEARCH;
                        er_reg <= 1'b1;
                        rxd_reg <= NIB_BAD_SSD;
                        crs_reg <= 1'b0;
                    end
                end
                RX_FRAME: begin
                    if (esd_pair || idle_pair) begin
                        rx_st_reg <= RX_SEARCH;
                        dv_reg <= 1'b0;
                        crs_reg <= 1'b0;
                        er_reg <= 1'b0;
                        rxd_reg <= NIB_NONE;
                    end else begin
                        rxd_reg <= dec_prev[3:0];
                        er_reg <= !dec_prev[4];
                    end
                    prev_reg <= grp_now;
                end
                default: begin
                    er_reg <= 1'b0;
                    rxd_reg <= NIB_NONE;
                end
            endcase
        end
    end

    // Sleep notice only outside frames, where an all-zero run cannot be data
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_reg <= 1'b0;
            rx_stb_reg <= 1'b0;
        end else begin
            sleep_reg <= grp_evt && rx_st_reg == RX_SEARCH && sh_next == RUN_ZEROS;
            rx_stb_reg <= grp_evt;
        end
    end

    assign mii_rxd_out = rxd_reg;
    assign mii_rx_dv_out = dv_reg;
    assign mii_rx_er_out = er_reg;
    assign mii_crs_out = crs_reg;
    assign mii_rx_stb_out = rx_stb_reg;
    assign rx_sleep_out = sleep_reg;
    assign rx_locked_out = locked_reg;

    sequence s_ssd_ok;
        rx_st_reg == RX_K && grp_evt && grp_now == CG_K && !wd_expire;
    endsequence
    sequence s_two_preamble;
        (mii_rxd_out == NIB_PREAMBLE && mii_rx_dv_out) ##5
            (mii_rxd_out == NIB_PREAMBLE && mii_rx_dv_out);
    endsequence
    property p_rx_sof;
        s_ssd_ok |=> s_two_preamble;
    endproperty
    a_rx_sof: assert property (p_rx_sof) else $error("Start delimiter not decoded");

    property p_rx_bad_ssd;
        (rx_st_reg == RX_K && grp_evt && grp_now != CG_K && !wd_expire) |=>
            (mii_rx_er_out && mii_rxd_out == NIB_BAD_SSD && !mii_rx_dv_out);
    endproperty
    a_rx_bad_ssd: assert property (p_rx_bad_ssd) else $error("Bad delimiter not flagged");

    property p_rx_wd;
        wd_expire |=> (!rx_locked_out && !mii_rx_dv_out && !mii_crs_out);
    endproperty
    a_rx_wd: assert property (p_rx_wd) else $error("Window expiry did not abort");

    property p_rx_end;
        (rx_st_reg == RX_FRAME && grp_evt && !wd_expire && (esd_pair || idle_pair)) |=>
            (!mii_rx_dv_out && !mii_crs_out);
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("Frame end not honoured");

    property p_rx_lone_r;
        (rx_st_reg == RX_FRAME && grp_evt && !wd_expire && grp_now == CG_R && !esd_pair)
            |-> ##6 mii_rx_er_out;
    endproperty
    a_rx_lone_r: assert property (p_rx_lone_r) else $error("Stray R not flagged");
endmodule // fepcs_codec

// [rtl/fepcs_pkg.sv]
// Shared constants, states and code-group lookups of the 100BASE-TX coding path
package fepcs_pkg;
    // ----------------------------------------------------------------
    // Code-group framing
    // ----------------------------------------------------------------
    localparam logic [2:0] GRP_LAST = 3'h4; // Last bit slot of a five-bit group
    localparam logic [2:0] GRP_PRE = 3'h3; // Slot just before the last slot of a group
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_H = 5'h04;
    localparam logic [4:0] CG_P = 5'h00;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD = 4'hE;
    localparam logic [3:0] NIB_NONE = 4'h0;
    localparam int CARRIER_MAX_ONES = 2; // Three zeros: a /J/ after idle first fills the window here

    // ----------------------------------------------------------------
    // Scrambler and synchronisation
    // ----------------------------------------------------------------
    localparam int TAP_A = 10; // x^11 term
    localparam int TAP_B = 8; // x^9 term
    localparam logic [5:0] SEED_FIX = 6'h2B; // Top bit set keeps the seed nonzero
    localparam logic [5:0] LOCK_BITS = 6'h3C;
    localparam logic [9:0] RUN_ONES = 10'h3FF; // Two idle groups, any phase
    localparam logic [9:0] RUN_ZEROS = 10'h000; // Two sleep groups, any phase
    localparam int CLK_MHZ = 20;
    localparam int WINDOW_US = 40;
    localparam int WINDOW_BYTES = 4000;
    localparam int MAX_FRAME_BYTES = 1514;
    localparam int CODE_BITS_PER_BYTE = 10;
    // One code bit per clock, so the window is counted in code bits
    localparam int WINDOW_CYC = WINDOW_BYTES * CODE_BITS_PER_BYTE;

    // ----------------------------------------------------------------
    // Line levels and states
    // ----------------------------------------------------------------
    localparam logic [1:0] MLT_ZERO = 2'h0;
    localparam logic [1:0] MLT_POS = 2'h1;
    localparam logic [1:0] MLT_NEG = 2'h3;
    typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fepcs_tx_state_t;
    typedef enum logic [1:0] {RX_SEARCH, RX_K, RX_FRAME} fepcs_rx_state_t;

    // Nibble to code-group
    function automatic logic [4:0] fepcs_enc(input logic [3:0] nib);
        case (nib)
            4'h0: fepcs_enc = 5'h1E;
            4'h1: fepcs_enc = 5'h09;
            4'h2: fepcs_enc = 5'h14;
            4'h3: fepcs_enc = 5'h15;
            4'h4: fepcs_enc = 5'h0A;
            4'h5: fepcs_enc = 5'h0B;
            4'h6: fepcs_enc = 5'h0E;
            4'h7: fepcs_enc = 5'h0F;
            4'h8: fepcs_enc = 5'h12;
            4'h9: fepcs_enc = 5'h13;
            4'hA: fepcs_enc = 5'h16;
            4'hB: fepcs_enc = 5'h17;
            4'hC: fepcs_enc = 5'h1A;
            4'hD: fepcs_enc = 5'h1B;
            4'hE: fepcs_enc = 5'h1C;
            default: fepcs_enc = 5'h1D;
        endcase
    endfunction

    // Code-group to {data valid, nibble}; every non-data group decodes invalid
    function automatic logic [4:0] fepcs_dec(input logic [4:0] grp);
        logic [4:0] r;
        r = 5'h00;
        for (int n = 0; n < 16; n++) begin
            if (fepcs_enc(4'(n)) == grp) begin
                r = {1'b1, 4'(n)};
            end
        end
        return r;
    endfunction
endpackage

// [rtl/fepcs_tx_if.sv]
// Code-group hand-off from the encoder to the transmit line stage
`timescale 1ns/1ps
interface fepcs_tx_if;
    logic [4:0] grp;
    logic load;
    modport enc (output grp, output load);
    modport line (input grp, input load);
endinterface

// [rtl/fepcs_tx_line.sv]
// Transmit line stage: serializer, scrambler, NRZI and MLT-3
`timescale 1ns/1ps
module fepcs_tx_line
    import fepcs_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [4:0] phy_addr_in,
    fepcs_tx_if.line tx_if,
    output logic tx_nrzi_out,
    output logic [1:0] tx_mlt3_out
);
    // ----------------------------------------------------------------
    // Serializer and scrambler
    // ----------------------------------------------------------------
    logic [4:0] sh_reg;
    logic [10:0] key_reg;
    logic seeded_reg;
    logic [1:0] phase_reg;
    logic nrzi_reg;
    logic [1:0] mlt3_reg;

    // Group bits leave most significant first
    wire cur_bit = tx_if.load ? tx_if.grp[4] : sh_reg[4];
    wire pred = key_reg[TAP_A] ^ key_reg[TAP_B];
    wire sbit = cur_bit ^ pred;
    wire [1:0] phase_next = 2'(phase_reg + {1'b0, sbit});
    wire [1:0] level_next = phase_next[0] ? (phase_next[1] ? MLT_NEG : MLT_POS) : MLT_ZERO;

    // Shift register refills with ones so a late load still looks idle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sh_reg <= CG_IDLE;
        end else if (tx_if.load) begin
            sh_reg <= {tx_if.grp[3:0], 1'b1};
        end else begin
            sh_reg <= {sh_reg[3:0], 1'b1};
        end
    end

    // Address is a live port, so the seed is taken after reset, not under it
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            key_reg <= '0;
            seeded_reg <= 1'b0;
        end else if (!seeded_reg) begin
            key_reg <= {SEED_FIX[4:0], phy_addr_in, SEED_FIX[5]};
            seeded_reg <= 1'b1;
        end else begin
            key_reg <= {key_reg[9:0], pred};
        end
    end

    // One code bit per clock stands in for the 125 MHz bit slot
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nrzi_reg <= 1'b0;
            phase_reg <= 2'h0;
            mlt3_reg <= MLT_ZERO;
        end else begin
            nrzi_reg <= nrzi_reg ^ sbit;
            phase_reg <= phase_next;
            mlt3_reg <= level_next;
        end
    end

    assign tx_nrzi_out = nrzi_reg;
    assign tx_mlt3_out = mlt3_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_mlt3_step;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (seeded_reg && sbit) |=> (tx_mlt3_out != $past(tx_mlt3_out));
    endproperty
    a_mlt3_step: assert property (p_mlt3_step) else $error("MLT-3 did not step on a one");

    property p_mlt3_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (seeded_reg && !sbit) |=> ($stable(tx_mlt3_out) && $stable(tx_nrzi_out));
    endproperty
    a_mlt3_hold: assert property (p_mlt3_hold) else $error("Line level moved on a zero");

    property p_seed;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(seeded_reg) |-> (key_reg[10:1] == {SEED_FIX[4:0], $past(phy_addr_in)});
    endproperty
    a_seed: assert property (p_seed) else $error("Scrambler seed not from address");
endmodule // fepcs_tx_line

// [tb/fepcs_line_echo.sv]
// Far-end line model: turns the NRZI line stream back into code bits
`timescale 1ns/1ps
module fepcs_line_echo (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic nrzi_in,
    output logic bit_out
);
    logic last_reg;
    // Previous line level; a change in level carries a one
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            last_reg <= 1'h0;
        else
            last_reg <= nrzi_in;
    end
    assign bit_out = nrzi_in ^ last_reg;
endmodule // fepcs_line_echo

// [tb/tb.sv]
// Self-checking loopback bench for the coding path
`timescale 1ns/1ps
module tb;
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    logic ref_clk_in, rst_n_in, tx_en, tx_er, lpi, tx_stb, nrzi, rx_bit;
    logic rx_stb, dv, er, crs, sleep, locked, pn, lost;
    logic [4:0] addr;
    logic [3:0] txd, rxd;
    logic [1:0] mlt, pm;
    logic [3:0] rxq[$];
    logic [63:0] s0, s1;
    int fails, check_count, er_seen, sleep_seen;

    // Short sync window so the abort case fits; still above a normal frame
    fepcs_codec #(.WINDOW_CYCLES(400)) dut (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .phy_addr_in(addr),
        .mii_tx_en_in(tx_en),
        .mii_tx_er_in(tx_er),
        .mii_txd_in(txd),
        .lpi_req_in(lpi),
        .rx_bit_in(rx_bit),
        .mii_tx_stb_out(tx_stb),
        .tx_nrzi_out(nrzi),
        .tx_mlt3_out(mlt),
        .mii_rx_stb_out(rx_stb),
        .mii_rxd_out(rxd),
        .mii_rx_dv_out(dv),
        .mii_rx_er_out(er),
        .mii_crs_out(crs),
        .rx_sleep_out(sleep),
        .rx_locked_out(locked)
    );
    fepcs_line_echo echo (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .nrzi_in(nrzi),
        .bit_out(rx_bit)
    );

    initial begin
        ref_clk_in = 1'h0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // Line and receive monitor; reads only values settled before the edge
    always @(posedge ref_clk_in) begin
        if (rst_n_in === 1'h1)
            chk("mlt3 step", nrzi !== pn, mlt !== pm);
        pn = nrzi;
        pm = mlt;
        if (rx_stb === 1'h1 && dv === 1'h1)
            rxq.push_back(rxd);
        if (rx_stb === 1'h1 && er === 1'h1)
            er_seen++;
        if (sleep === 1'h1)
            sleep_seen++;
        if (locked !== 1'h1)
            lost = 1'h1;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Drive one nibble now and return at the edge that takes it
    task automatic nib(input logic en, input logic e, input logic [3:0] d);
        tx_en <= en;
        tx_er <= e;
        txd <= d;
        do @(negedge ref_clk_in); while (tx_stb !== 1'h1);
        @(posedge ref_clk_in);
    endtask

    task automatic do_reset(input logic [4:0] a);
        rst_n_in <= 1'h0;
        addr <= a;
        repeat (10) @(posedge ref_clk_in);
        chk("reset outputs", 32'h0, {dv, crs, er, locked, mlt, nrzi});
        rst_n_in <= 1'h1;
    endtask

    task automatic grab(output logic [63:0] s);
        for (int i = 0; i < 64; i++) begin
            @(posedge ref_clk_in);
            s[i] = nrzi;
        end
    endtask

    // Bounded wait: lock needs 61 idle bits after any disturbance
    task automatic wait_lock();
        for (int i = 0; i < 400 && locked !== 1'h1; i++)
            @(posedge ref_clk_in);
        chk("locked", 32'h1, locked);
    endtask

    // Two preamble nibbles become /J/K/, then n data nibbles, bad one errored
    task automatic frame(input int n, input int bad);
        rxq = {};
        er_seen = 0;
        nib(1'h1, 1'h0, 4'h5);
        nib(1'h1, 1'h0, 4'h5);
        for (int i = 0; i < n; i++)
            nib(1'h1, i == bad, 4'(i));
        nib(1'h0, 1'h0, 4'h0);
        repeat (40) @(posedge ref_clk_in);
        chk("frame end", 32'h0, {dv, crs});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_in = 1'h0;
        addr = 5'h0;
        tx_en = 1'h0;
        tx_er = 1'h0;
        txd = 4'h0;
        lpi = 1'h0;
        do_reset(5'h01);
        grab(s0);
        do_reset(5'h12);
        grab(s1);
        chk("seeds differ", 32'h1, s0 !== s1);
        wait_lock();
        frame(16, -1);
        chk("rx count", 32'h12, rxq.size());
        for (int i = 0; i < 18; i++)
            chk("rx nibble", (i < 2) ? 5 : i - 2, rxq[i]);
        chk("clean frame errors", 32'h0, er_seen);
        frame(4, 2);
        chk("tx error marks", 32'h1, er_seen);
        sleep_seen = 0;
        lpi <= 1'h1;
        repeat (40) @(posedge ref_clk_in);
        lpi <= 1'h0;
        repeat (40) @(posedge ref_clk_in);
        chk("sleep notice", 32'h1, sleep_seen > 0);
        wait_lock();
        lost = 1'h0;
        frame(90, -1);
        chk("lock lost", 32'h1, lost);
        wait_lock();
        give_verdict();
    end

    // Watchdog: the sequence needs well under 10000 cycles
    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
endmodule // tb
